// file: sbcwd_top.sv
`timescale 1ns/1ps
module sbcwd_top #(
   parameter int CYC_PER_MS = sbcwd_pkg::CYC_PER_MS
) (
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic I_CE,
   // Decoded serial register access
   input wire logic I_SPI_VALID,
   input wire logic I_SPI_WRITE,
   input wire logic [6:0] I_SPI_ADDR,
   input wire logic [7:0] I_SPI_WDATA,
   output logic [7:0] O_SPI_RDATA,
   output logic O_SPI_DISCARD,
   // Chip operating mode and configuration levels
   input wire logic I_MODE_NORMAL,
   input wire logic I_MODE_STANDBY,
   input wire logic I_MODE_SLEEP,
   input wire logic I_WAKE_PENDING,
   input wire logic I_FORCED_NORMAL_CONFIG,
   input wire logic I_SW_DEVELOPMENT_CONFIG,
   input wire logic I_OVERFLOW_RESET_FLAG,
   input wire logic I_SERIAL_FAILURE_ENABLE,
   input wire logic I_OVERTEMP_WARNING,
   // Reset causes reported by the rest of the chip
   input wire logic I_CAUSE_CAN_WAKE,
   input wire logic I_CAUSE_PIN_WAKE,
   input wire logic I_CAUSE_DIAG_WAKE,
   input wire logic I_CAUSE_OTP_EXIT,
   input wire logic I_CAUSE_FRAME_ERR,
   input wire logic I_CAUSE_PIN_PULLED,
   input wire logic I_CAUSE_UNDERVOLT,
   input wire logic I_CAUSE_ILL_SLEEP,
   // Results towards the mode control
   output logic O_RESET_REQ,
   output logic O_SERIAL_FAILURE_EVENT,
   output logic O_WD_OVERFLOW_EVENT,
   output logic [2:0] O_WD_ACTIVE_MODE,
   output logic [7:0] O_MAIN_STATUS
);
   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   // The period timer needs at least one cycle per millisecond
   generate
      if (CYC_PER_MS < 1) begin : g_bad_rate
         $error("CYC_PER_MS must be at least one");
      end
   endgenerate

   // ****************************************************************
   // Stored state
   // ****************************************************************
   logic [2:0] beh_reg; // Selected watchdog behaviour code
   logic [2:0] beh_next;
   logic [3:0] per_reg; // Selected period code
   logic [3:0] per_next;
   logic otw_reg; // Registered overtemperature warning
   logic normal_pend_reg; // High until Normal mode is seen
   logic [4:0] cause_reg; // Latest reset cause
   logic [4:0] cause_next;
   logic [2:0] act_reg; // Behaviour active in the last cycle
   logic [7:0] rdata_reg; // Read data towards the serial port
   logic discard_reg; // Access refused pulse
   logic rst_req_reg; // Reset mode request pulse
   logic fail_reg; // Serial failure event pulse
   logic ovf_evt_reg; // Overflow without reset pulse

   // ****************************************************************
   // Access decode
   // ****************************************************************
   // Fields of the incoming control write
   wire [2:0] wr_beh = I_SPI_WDATA[sbcwd_pkg::BEH_MSB:sbcwd_pkg::BEH_LSB];
   wire [3:0] wr_per = I_SPI_WDATA[sbcwd_pkg::PER_MSB:sbcwd_pkg::PER_LSB];
   wire wr_beh_ok; // Written behaviour code is legal
   wire wr_per_ok; // Written period code is legal
   wire cur_beh_ok; // Stored behaviour code is legal
   wire [12:0] cur_ms; // Length of the stored period
   // Control register write strobe
   wire ctrl_wr = I_SPI_VALID && I_SPI_WRITE &&
      (I_SPI_ADDR == sbcwd_pkg::WDG_CTRL_ADDR);
   // Reads of either register
   wire ctrl_rd = I_SPI_VALID && !I_SPI_WRITE &&
      (I_SPI_ADDR == sbcwd_pkg::WDG_CTRL_ADDR);
   wire stat_rd = I_SPI_VALID && !I_SPI_WRITE &&
      (I_SPI_ADDR == sbcwd_pkg::MAIN_STATUS_ADDR);
   // Both fields must decode, otherwise nothing is stored
   wire wr_codes_ok = wr_beh_ok && wr_per_ok;
   wire bad_code = ctrl_wr && !wr_codes_ok;
   // Any change of behaviour or period compared with what is held
   wire cfg_change = (wr_beh != beh_reg) || (wr_per != per_reg);
   // Reconfiguration in Normal mode is treated as a fault
   wire illegal_cfg = ctrl_wr && wr_codes_ok && I_MODE_NORMAL &&
      cfg_change;
   // A clean write stores the fields and triggers the watchdog
   wire accept = ctrl_wr && wr_codes_ok && !illegal_cfg;

   // Write-side decoder
   sbcwd_code_dec u_wr_dec (
      .i_beh(wr_beh),
      .i_per(wr_per),
      .o_beh_ok(wr_beh_ok),
      .o_per_ok(wr_per_ok),
      .o_period_ms()
   );
   // Decoder of the held setting, gives the running period
   sbcwd_code_dec u_cur_dec (
      .i_beh(beh_reg),
      .i_per(per_reg),
      .o_beh_ok(cur_beh_ok),
      .o_per_ok(),
      .o_period_ms(cur_ms)
   );

   // ****************************************************************
   // Active behaviour selection
   // ****************************************************************
   // Working copies of the held code, legal by construction
   wire sel_window = cur_beh_ok && (beh_reg == sbcwd_pkg::BEH_WINDOW);
   wire sel_timeout = cur_beh_ok && (beh_reg == sbcwd_pkg::BEH_TIMEOUT);
   wire sel_auto = cur_beh_ok && (beh_reg == sbcwd_pkg::BEH_AUTONOMOUS);
   // Standby or Sleep lets the watchdog wake the host cyclically
   wire low_power = I_MODE_STANDBY || I_MODE_SLEEP;
   // Autonomous runs in Normal, or in Standby with a wake pending
   wire auto_run = sel_auto && !I_SW_DEVELOPMENT_CONFIG &&
      (I_MODE_NORMAL || (I_MODE_STANDBY && I_WAKE_PENDING));
   // Window and Timeout selections both count in the low modes
   wire wt_run = (sel_window || sel_timeout) &&
      (low_power || I_MODE_NORMAL);
   // Window is only opened in Normal mode
   wire win_on = sel_window && I_MODE_NORMAL;
   sbcwd_pkg::sbcwd_mode_t act_mode; // Behaviour in force now
   // Forced normal overrides every other setting
   always_comb begin
      if (I_FORCED_NORMAL_CONFIG) begin
         act_mode = sbcwd_pkg::WD_OFF;
      end else if (win_on) begin
         act_mode = sbcwd_pkg::WD_WINDOW;
      end else if (wt_run || auto_run) begin
         act_mode = sbcwd_pkg::WD_TIMEOUT;
      end else begin
         act_mode = sbcwd_pkg::WD_OFF;
      end
   end
   // A change of behaviour restarts the count in the new regime
   wire mode_change = (act_mode != act_reg);

   // ****************************************************************
   // Timer and its outcomes
   // ****************************************************************
   sbcwd_tmr_if tif ();
   sbcwd_timer #(
      .CYC_PER_MS(CYC_PER_MS)
   ) u_timer (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_ce(I_CE),
      .tif(tif)
   );
   // Trigger inside the closed first half of a window period
   wire early = accept && (act_mode == sbcwd_pkg::WD_WINDOW) &&
      tif.first_half;
   // The count ran out while the watchdog was active
   wire ovf_hit = tif.overflow && (act_reg != sbcwd_pkg::WD_OFF);
   wire ovf_sleep = ovf_hit && I_MODE_SLEEP;
   // Overflow that forces a reset outside Sleep
   wire ovf_reset = ovf_hit && !I_MODE_SLEEP &&
      ((act_reg == sbcwd_pkg::WD_WINDOW) || I_OVERFLOW_RESET_FLAG);
   // Overflow that only reports
   wire ovf_quiet = ovf_hit && !I_MODE_SLEEP && !ovf_reset;
   // Any watchdog-caused reset of the chip
   wire wd_reset = early || ovf_sleep || ovf_reset || illegal_cfg;
   assign tif.run = (act_mode != sbcwd_pkg::WD_OFF);
   // New period or behaviour acts from the write onward
   assign tif.restart = accept || mode_change || wd_reset;
   assign tif.period_ms = cur_ms;

   // ****************************************************************
   // Next values of the configuration and cause
   // ****************************************************************
   // Stored fields change only on an accepted write
   assign beh_next = accept ? wr_beh : beh_reg;
   assign per_next = accept ? wr_per : per_reg;
   // Watchdog causes first, then the chip causes in fixed order;
   // simultaneous causes are rare, one code must win
   always_comb begin
      if (illegal_cfg) begin
         cause_next = sbcwd_pkg::RC_ILLEGAL_CFG;
      end else if (early) begin
         cause_next = sbcwd_pkg::RC_WD_EARLY;
      end else if (ovf_sleep) begin
         cause_next = sbcwd_pkg::RC_WD_SLEEP;
      end else if (ovf_reset) begin
         cause_next = sbcwd_pkg::RC_WD_OVERFLOW;
      end else if (I_CAUSE_UNDERVOLT) begin
         cause_next = sbcwd_pkg::RC_V1_UNDERVOLT;
      end else if (I_CAUSE_PIN_PULLED) begin
         cause_next = sbcwd_pkg::RC_PIN_PULLED;
      end else if (I_CAUSE_ILL_SLEEP) begin
         cause_next = sbcwd_pkg::RC_ILL_SLEEP;
      end else if (I_CAUSE_OTP_EXIT) begin
         cause_next = sbcwd_pkg::RC_OTP_EXIT;
      end else if (I_CAUSE_CAN_WAKE) begin
         cause_next = sbcwd_pkg::RC_CAN_WAKE;
      end else if (I_CAUSE_PIN_WAKE) begin
         cause_next = sbcwd_pkg::RC_PIN_WAKE;
      end else if (I_CAUSE_DIAG_WAKE) begin
         cause_next = sbcwd_pkg::RC_DIAG_WAKE;
      end else if (I_CAUSE_FRAME_ERR) begin
         cause_next = sbcwd_pkg::RC_FRAME_ERR;
      end else begin
         cause_next = cause_reg;
      end
   end

   // ****************************************************************
   // Read data and status word
   // ****************************************************************
   // Reserved bits read as zero
   wire [7:0] ctrl_word = {beh_reg, 1'b0, per_reg};
   wire [7:0] stat_word = {1'b0, otw_reg, normal_pend_reg, cause_reg};
   // Unmapped addresses read as zero
   wire [7:0] rd_mux = ctrl_rd ? ctrl_word :
      (stat_rd ? stat_word : 8'h00);

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   // Power-up defaults: Timeout behaviour, 128 ms period
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         beh_reg <= sbcwd_pkg::BEH_RESET;
         per_reg <= sbcwd_pkg::PER_RESET;
      end else if (I_CE) begin
         beh_reg <= beh_next;
         per_reg <= per_next;
      end
   end

   // ****************************************************************
   // Status registers
   // ****************************************************************
   // Writes to the status address are not decoded, so it stays
   // read only and raises nothing
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         otw_reg <= 1'b0;
         normal_pend_reg <= 1'b1;
         cause_reg <= sbcwd_pkg::RC_POWER_ON;
      end else if (I_CE) begin
         otw_reg <= I_OVERTEMP_WARNING;
         if (I_MODE_NORMAL) begin
            normal_pend_reg <= 1'b0;
         end
         cause_reg <= cause_next;
      end
   end

   // ****************************************************************
   // Event pulses and read data
   // ****************************************************************
   // Pulses last one enabled cycle; the mode control latches them
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         act_reg <= sbcwd_pkg::WD_OFF;
         rdata_reg <= 8'h00;
         discard_reg <= 1'b0;
         rst_req_reg <= 1'b0;
         fail_reg <= 1'b0;
         ovf_evt_reg <= 1'b0;
      end else if (I_CE) begin
         act_reg <= act_mode;
         if (ctrl_rd || stat_rd || I_SPI_VALID) begin
            rdata_reg <= rd_mux;
         end
         discard_reg <= bad_code;
         rst_req_reg <= wd_reset;
         fail_reg <= I_SERIAL_FAILURE_ENABLE &&
            (bad_code || illegal_cfg);
         ovf_evt_reg <= ovf_quiet;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign O_SPI_RDATA = rdata_reg;
   assign O_SPI_DISCARD = discard_reg;
   assign O_RESET_REQ = rst_req_reg;
   assign O_SERIAL_FAILURE_EVENT = fail_reg;
   assign O_WD_OVERFLOW_EVENT = ovf_evt_reg;
   assign O_WD_ACTIVE_MODE = act_reg;
   assign O_MAIN_STATUS = stat_word;
endmodule

// file: sbcwd_pkg.sv
// ****************************************************************
// Shared constants of the watchdog and reset status block
// ****************************************************************
package sbcwd_pkg;
   // Register addresses on the serial access port
   localparam logic [6:0] WDG_CTRL_ADDR = 7'h00;
   localparam logic [6:0] MAIN_STATUS_ADDR = 7'h03;
   // Watchdog control field positions
   localparam int BEH_MSB = 7;
   localparam int BEH_LSB = 5;
   localparam int PER_MSB = 3;
   localparam int PER_LSB = 0;
   // Main status field positions
   localparam int OTW_BIT = 6;
   localparam int NORMAL_PEND_BIT = 5;
   localparam int CAUSE_MSB = 4;
   // Behaviour codes, redundant so one flipped bit never decodes
   localparam logic [2:0] BEH_AUTONOMOUS = 3'h1;
   localparam logic [2:0] BEH_TIMEOUT = 3'h2;
   localparam logic [2:0] BEH_WINDOW = 3'h4;
   // Period codes and their lengths in milliseconds
   localparam logic [3:0] PER_8 = 4'h8;
   localparam logic [3:0] PER_16 = 4'h1;
   localparam logic [3:0] PER_32 = 4'h2;
   localparam logic [3:0] PER_64 = 4'hb;
   localparam logic [3:0] PER_128 = 4'h4;
   localparam logic [3:0] PER_256 = 4'hd;
   localparam logic [3:0] PER_1024 = 4'he;
   localparam logic [3:0] PER_4096 = 4'h7;
   localparam int MS_W = 13;
   localparam logic [12:0] MS_8 = 13'h0008;
   localparam logic [12:0] MS_16 = 13'h0010;
   localparam logic [12:0] MS_32 = 13'h0020;
   localparam logic [12:0] MS_64 = 13'h0040;
   localparam logic [12:0] MS_128 = 13'h0080;
   localparam logic [12:0] MS_256 = 13'h0100;
   localparam logic [12:0] MS_1024 = 13'h0400;
   localparam logic [12:0] MS_4096 = 13'h1000;
   // Reset values of the control fields
   localparam logic [2:0] BEH_RESET = BEH_TIMEOUT;
   localparam logic [3:0] PER_RESET = PER_128;
   // Reset cause codes
   localparam logic [4:0] RC_POWER_ON = 5'h00;
   localparam logic [4:0] RC_CAN_WAKE = 5'h01;
   localparam logic [4:0] RC_PIN_WAKE = 5'h04;
   localparam logic [4:0] RC_WD_SLEEP = 5'h0c;
   localparam logic [4:0] RC_DIAG_WAKE = 5'h0d;
   localparam logic [4:0] RC_WD_EARLY = 5'h0e;
   localparam logic [4:0] RC_WD_OVERFLOW = 5'h0f;
   localparam logic [4:0] RC_ILLEGAL_CFG = 5'h10;
   localparam logic [4:0] RC_PIN_PULLED = 5'h11;
   localparam logic [4:0] RC_OTP_EXIT = 5'h12;
   localparam logic [4:0] RC_V1_UNDERVOLT = 5'h13;
   localparam logic [4:0] RC_ILL_SLEEP = 5'h14;
   localparam logic [4:0] RC_FRAME_ERR = 5'h16;
   // Timing: one millisecond at a 10 ns clock
   localparam int MS_IN_NS = 1000000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CYC_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
   // Active watchdog behaviour, one-hot
   typedef enum logic [2:0] {
      WD_OFF = 3'b001,
      WD_TIMEOUT = 3'b010,
      WD_WINDOW = 3'b100
   } sbcwd_mode_t;
endpackage

// file: sbcwd_tmr_if.sv
`timescale 1ns/1ps
// ****************************************************************
// Link between the control logic and the period timer
// ****************************************************************
interface sbcwd_tmr_if;
   logic run; // Timer counts while high
   logic restart; // Clears the timer this cycle
   logic [12:0] period_ms; // Active period length
   logic overflow; // One-cycle pulse at end of period
   logic first_half; // Level, inside the closed half of window
   modport ctrl (output run, output restart, output period_ms,
      input overflow, input first_half);
   modport tmr (input run, input restart, input period_ms,
      output overflow, output first_half);
endinterface

// file: sbcwd_code_dec.sv
`timescale 1ns/1ps
// ****************************************************************
// Decoder of the redundant behaviour and period codes
// ****************************************************************
module sbcwd_code_dec (
   input wire logic [2:0] i_beh,
   input wire logic [3:0] i_per,
   output logic o_beh_ok,
   output logic o_per_ok,
   output logic [12:0] o_period_ms
);
   // Only the exact codes count; any other pattern is refused
   assign o_beh_ok = (i_beh == sbcwd_pkg::BEH_AUTONOMOUS) ||
      (i_beh == sbcwd_pkg::BEH_TIMEOUT) ||
      (i_beh == sbcwd_pkg::BEH_WINDOW);
   // Period lookup, zero length marks an invalid code
   always_comb begin
      unique case (i_per)
         sbcwd_pkg::PER_8: o_period_ms = sbcwd_pkg::MS_8;
         sbcwd_pkg::PER_16: o_period_ms = sbcwd_pkg::MS_16;
         sbcwd_pkg::PER_32: o_period_ms = sbcwd_pkg::MS_32;
         sbcwd_pkg::PER_64: o_period_ms = sbcwd_pkg::MS_64;
         sbcwd_pkg::PER_128: o_period_ms = sbcwd_pkg::MS_128;
         sbcwd_pkg::PER_256: o_period_ms = sbcwd_pkg::MS_256;
         sbcwd_pkg::PER_1024: o_period_ms = sbcwd_pkg::MS_1024;
         sbcwd_pkg::PER_4096: o_period_ms = sbcwd_pkg::MS_4096;
         default: o_period_ms = 13'h0000;
      endcase
   end
   assign o_per_ok = (o_period_ms != 13'h0000);
endmodule

// file: sbcwd_timer.sv
`timescale 1ns/1ps
// ****************************************************************
// Millisecond period timer
// ****************************************************************
module sbcwd_timer #(
   parameter int CYC_PER_MS = sbcwd_pkg::CYC_PER_MS
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   sbcwd_tmr_if.tmr tif
);
   localparam int PW = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;
   localparam logic [PW-1:0] PRE_LAST = PW'(CYC_PER_MS - 1);
   // Refuse a prescale that cannot make a millisecond tick
   generate
      if (CYC_PER_MS < 1) begin : g_bad
         $error("CYC_PER_MS must be at least one");
      end
   endgenerate
   logic [PW-1:0] pre_reg; // Cycles inside the current millisecond
   logic [12:0] ms_reg; // Whole milliseconds elapsed
   logic ovf_reg; // Overflow pulse
   wire ms_tick = tif.run && (pre_reg == PRE_LAST);
   wire ms_last = (ms_reg == (tif.period_ms - 13'h0001));
   wire [12:0] half_ms = {1'b0, tif.period_ms[12:1]};
   assign tif.overflow = ovf_reg;
   assign tif.first_half = (ms_reg < half_ms);
   // Restart or stop clears the count, so new settings act at once
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pre_reg <= '0;
         ms_reg <= 13'h0000;
         ovf_reg <= 1'b0;
      end else if (i_ce) begin
         // A trigger landing on the last tick still counts as in time
         ovf_reg <= ms_tick && ms_last && !tif.restart;
         if (tif.restart || !tif.run) begin
            pre_reg <= '0;
            ms_reg <= 13'h0000;
         end else if (ms_tick) begin
            pre_reg <= '0;
            ms_reg <= ms_last ? 13'h0000 : ms_reg + 13'h0001;
         end else begin
            pre_reg <= pre_reg + PW'(1);
         end
      end
   end
endmodule

// file: sbcwd_top_monitor.sv
`timescale 1ns/1ps
// ****************************************
// Port checker of the watchdog block
// ****************************************
module sbcwd_monitor (
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic I_CE,
   input wire logic I_SPI_VALID,
   input wire logic I_SPI_WRITE,
   input wire logic [6:0] I_SPI_ADDR,
   input wire logic [7:0] I_SPI_WDATA,
   input wire logic [7:0] O_SPI_RDATA,
   input wire logic O_SPI_DISCARD,
   input wire logic I_MODE_NORMAL,
   input wire logic I_MODE_STANDBY,
   input wire logic I_MODE_SLEEP,
   input wire logic I_FORCED_NORMAL_CONFIG,
   input wire logic I_SERIAL_FAILURE_ENABLE,
   input wire logic I_OVERTEMP_WARNING,
   input wire logic O_RESET_REQ,
   input wire logic O_SERIAL_FAILURE_EVENT,
   input wire logic O_WD_OVERFLOW_EVENT,
   input wire logic [2:0] O_WD_ACTIVE_MODE,
   input wire logic [7:0] O_MAIN_STATUS
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_SYS_RST);
   // Taken access, and a control write whose codes do not decode
   wire acc = I_CE && I_SPI_VALID;
   wire beh_ok = I_SPI_WDATA[7:5] inside {3'h1, 3'h2, 3'h4};
   wire per_ok = I_SPI_WDATA[3:0] inside
      {4'h8, 4'h1, 4'h2, 4'hb, 4'h4, 4'hd, 4'he, 4'h7};
   wire bad_wr = acc && I_SPI_WRITE && I_SPI_ADDR == 7'h00 &&
      !(beh_ok && per_ok);
   wire no_mode = !(I_MODE_NORMAL || I_MODE_STANDBY || I_MODE_SLEEP);
   a_otw_follow: assert property (I_CE |=>
      O_MAIN_STATUS[6] == $past(I_OVERTEMP_WARNING)) else $error("otw");
   a_normal_sticky: assert property (!O_MAIN_STATUS[5] |=>
      !O_MAIN_STATUS[5]) else $error("normal flag set again");
   a_normal_clear: assert property (I_CE && I_MODE_NORMAL |=>
      !O_MAIN_STATUS[5]) else $error("normal flag not cleared");
   a_bad_discard: assert property (bad_wr |=> O_SPI_DISCARD)
      else $error("bad code kept");
   a_discard_cause: assert property (O_SPI_DISCARD |->
      $past(bad_wr)) else $error("good code discarded");
   a_fail_event: assert property (bad_wr &&
      I_SERIAL_FAILURE_ENABLE |=> O_SERIAL_FAILURE_EVENT)
      else $error("no failure event");
   a_forced_off: assert property (I_CE && I_FORCED_NORMAL_CONFIG
      |=> O_WD_ACTIVE_MODE == 3'h1) else $error("forced not off");
   a_other_off: assert property (I_CE && no_mode |=>
      O_WD_ACTIVE_MODE == 3'h1) else $error("off mode runs");
   a_status_read: assert property (acc && !I_SPI_WRITE &&
      I_SPI_ADDR == 7'h03 |=> O_SPI_RDATA == $past(O_MAIN_STATUS))
      else $error("status read");
   a_window_normal: assert property (O_WD_ACTIVE_MODE == 3'h4 |->
      $past(I_MODE_NORMAL)) else $error("window outside normal");
   c_discard: cover property (O_SPI_DISCARD);
   c_reset: cover property (O_RESET_REQ);
   c_overflow: cover property (O_WD_OVERFLOW_EVENT);
endmodule
bind sbcwd_top sbcwd_monitor u_mon (.*);

// file: sbcwd_host.sv
`timescale 1ns/1ps
// ****************************************
// Host model: one decoded register access per call
// ****************************************
module sbcwd_host (
   input wire logic i_clk,
   output logic o_valid,
   output logic o_write,
   output logic [6:0] o_addr,
   output logic [7:0] o_wdata
);
   initial begin
      o_valid = 1'b0;
      o_write = 1'b0;
      o_addr = 7'h7f;
      o_wdata = 8'h00;
   end
   // Held through the sampling edge; released address and data show the inverse
   task automatic acc(input logic wr, input logic [6:0] a,
      input logic [7:0] d);
      @(posedge i_clk);
      o_valid <= 1'b1;
      o_write <= wr;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_valid <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask
endmodule

// file: tb_sbc_watchdog_and_reset_status.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   bad_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_sbc_watchdog_and_reset_status;
   logic clk = 1'h0, rst = 1'h1, otw = 1'h0, orf = 1'h0, fen = 1'h0;
   logic fn = 1'h0, sd = 1'h0, wk = 1'h0;
   logic [1:0] md = 2'h0; // None, normal, standby, sleep
   logic [7:0] cz = 0; // Reset cause pulses
   logic v, w, dis, rq, fl, ov;
   logic [6:0] a;
   logic [7:0] d, rd, st, ctl, x;
   logic [2:0] am, em;
   int bad_count = 0, n_checks = 0, n, i;
   logic [4:0] codes [8] = '{5'h01, 5'h04, 5'h0d, 5'h12, 5'h16, 5'h11,
      5'h13, 5'h14};
   always #5 clk = ~clk;
   sbcwd_top #(.CYC_PER_MS(4)) u_dut (.I_CLK(clk), .I_SYS_RST(rst),
      .I_CE(1'b1), .I_SPI_VALID(v), .I_SPI_WRITE(w), .I_SPI_ADDR(a),
      .I_SPI_WDATA(d), .O_SPI_RDATA(rd), .O_SPI_DISCARD(dis),
      .I_MODE_NORMAL(md == 2'h1), .I_MODE_STANDBY(md == 2'h2),
      .I_MODE_SLEEP(md == 2'h3), .I_WAKE_PENDING(wk),
      .I_FORCED_NORMAL_CONFIG(fn), .I_SW_DEVELOPMENT_CONFIG(sd),
      .I_OVERFLOW_RESET_FLAG(orf), .I_SERIAL_FAILURE_ENABLE(fen),
      .I_OVERTEMP_WARNING(otw), .I_CAUSE_CAN_WAKE(cz[0]),
      .I_CAUSE_PIN_WAKE(cz[1]), .I_CAUSE_DIAG_WAKE(cz[2]),
      .I_CAUSE_OTP_EXIT(cz[3]), .I_CAUSE_FRAME_ERR(cz[4]),
      .I_CAUSE_PIN_PULLED(cz[5]), .I_CAUSE_UNDERVOLT(cz[6]),
      .I_CAUSE_ILL_SLEEP(cz[7]), .O_RESET_REQ(rq),
      .O_SERIAL_FAILURE_EVENT(fl), .O_WD_OVERFLOW_EVENT(ov),
      .O_WD_ACTIVE_MODE(am), .O_MAIN_STATUS(st));
   sbcwd_host u_host (.i_clk(clk), .o_valid(v), .o_write(w), .o_addr(a),
      .o_wdata(d));
   // Expected active mode: 1 off, 2 timeout, 4 window
   function automatic logic [2:0] exp_mode(input logic [2:0] b);
      if (fn || md == 2'h0) return 3'h1;
      if (b == 3'h1) return (!sd && (md == 2'h1 || (md == 2'h2 && wk))) ?
         3'h2 : 3'h1;
      if (md == 2'h1 && b == 3'h4) return 3'h4;
      return 3'h2;
   endfunction
   function automatic logic ok(input logic [7:0] y);
      return y[7:5] inside {3'h1, 3'h2, 3'h4} && y[3:0] inside
         {4'h8, 4'h1, 4'h2, 4'hb, 4'h4, 4'hd, 4'he, 4'h7};
   endfunction
   task automatic wr(input logic [7:0] y);
      u_host.acc(1'b1, 7'h00, y);
      #1;
   endtask
   task automatic rdc(input logic [6:0] ad, input logic [7:0] e,
      input string nm);
      u_host.acc(1'b0, ad, 8'h00);
      #1;
      `CHK(nm, e, rd)
   endtask
   // Counts cycles until an overflow or reset request, bounded
   task automatic wait_ev();
      n = 0;
      while (!(ov || rq) && n < 80) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   task automatic report_and_stop;
      if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      report_and_stop;
   end
   initial begin
      n = $urandom(30694);
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rdc(7'h03, 8'h20, "status");
      ctl = 8'h44;
      rdc(7'h00, ctl, "ctrl");
      for (i = 0; i < 8; i++) begin
         cz <= 8'h01 << i;
         @(posedge clk);
         cz <= 8'h00;
         rdc(7'h03, {3'h1, codes[i]}, "cause");
      end
      md <= 2'h2;
      fen <= 1'h1;
      // A write to the status address changes and raises nothing
      u_host.acc(1'h1, 7'h03, 8'hff);
      #1;
      `CHK("ro_discard", 1'h0, dis)
      `CHK("ro_failure", 1'h0, fl)
      rdc(7'h03, 8'h34, "status_ro");
      // Random control writes in standby, the first two refused
      for (i = 0; i < 24; i++) begin
         x = (i == 0) ? 8'h63 : (i == 1) ? 8'h49 : 8'($urandom);
         otw <= 1'($urandom);
         wr(x);
         `CHK("discard", !ok(x), dis)
         `CHK("failure", !ok(x), fl)
         if (ok(x)) ctl = x & 8'hef;
         rdc(7'h00, ctl, "ctrl");
         `CHK("otw", otw, st[6])
      end
      // Active mode over chip modes and configuration levels
      for (i = 0; i < 40; i++) begin
         md <= 2'h2;
         wr({3'h1 << (i % 3), 5'h08});
         md <= (i == 0) ? 2'h1 : 2'($urandom);
         fn <= 1'($urandom);
         sd <= 1'($urandom);
         wk <= 1'($urandom);
         repeat (3) @(posedge clk);
         #1;
         em = exp_mode(3'h1 << (i % 3));
         `CHK("mode", em, am)
      end
      {fn, sd, wk, orf} <= 4'h0;
      md <= 2'h2;
      wr(8'h48);
      repeat (16) @(posedge clk);
      wr(8'h48);
      wait_ev();
      `CHK("ovf", 1'h1, ov)
      `CHK("ovf_len", 1'h1, n > 28 && n < 38)
      orf <= 1'h1;
      wr(8'h48);
      wait_ev();
      `CHK("ovf_rst", 1'h1, rq)
      rdc(7'h03, {1'h0, otw, 1'h0, 5'h0f}, "cause");
      orf <= 1'h0;
      wr(8'h48);
      md <= 2'h3;
      wait_ev();
      rdc(7'h03, {1'h0, otw, 1'h0, 5'h0c}, "cause");
      md <= 2'h2;
      wr(8'h88);
      md <= 2'h1;
      repeat (3) @(posedge clk);
      wr(8'h88);
      `CHK("early", 1'h1, rq)
      rdc(7'h03, {1'h0, otw, 1'h0, 5'h0e}, "cause");
      md <= 2'h2;
      @(posedge clk);
      md <= 2'h1;
      repeat (20) @(posedge clk);
      wr(8'h88);
      `CHK("in_window", 1'h0, rq)
      wr(8'h48);
      `CHK("illegal", 1'h1, rq)
      `CHK("failure", 1'h1, fl)
      rdc(7'h03, {1'h0, otw, 1'h0, 5'h10}, "cause");
      rdc(7'h00, 8'h88, "ctrl");
      report_and_stop;
   end
endmodule
